// ### hdl/sbtc_prescale.sv
// sbtc_prescale: 1/2/4/8 prescaler on a count-enable pulse
// assumes tick_in is a one-cycle pulse on clk_in
`timescale 1ns/1ns
`default_nettype none
module sbtc_prescale #(
	parameter int WIDTH = 3
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       clear_in,
	input  wire logic [1:0] sel_in,
	input  wire logic       tick_in,
	output logic            tick_out
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] mask;

	always_comb begin
		unique case (sel_in)
			2'b00: mask = 3'h0;
			2'b01: mask = 3'h1;
			2'b10: mask = 3'h3;
			2'b11: mask = 3'h7;
		endcase
	end

	assign tick_out = tick_in && ((cnt_reg & mask) == mask);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg <= 3'h0;
		end else if (clear_in) begin
			cnt_reg <= 3'h0;
		end else if (tick_in) begin
			cnt_reg <= tick_out ? 3'h0 : cnt_reg + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ### hdl/sbtc_sync3.sv
// sbtc_sync3: three-flop synchroniser, change counts once flops two and three agree
// assumes the input is asynchronous to clk_in
`timescale 1ns/1ns
`default_nettype none
module sbtc_sync3 (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic d_in,
	output var  logic q_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// a level is accepted only when two stable samples agree
			if (s2_reg == s3_reg) begin
				q_out <= s3_reg;
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/sbtc_timer.sv
// sbtc_timer: 16-bit timer/counter with prescaler, buffered 16-bit access,
// overflow flag and special-event reset, reached over avalon-mm
// assumes ref_clk_in is the instruction clock; external pins are asynchronous
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module sbtc_timer
	import sbtc_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        ext_count_clock_pin_in,
	input  wire logic        companion_osc_clk_in,
	input  wire logic [1:0]  shared_pins_in,
	input  wire logic        capcomp_unit_one_trig_in,
	input  wire logic        capcomp_unit_two_trig_in,
	input  wire logic [3:0]  capcomp_unit_one_mode_in,
	input  wire logic [3:0]  capcomp_unit_two_mode_in,
	output logic [1:0]       shared_pins_read_out,
	output logic             unit_one_uses_this_out,
	output logic             unit_two_uses_this_out,
	output logic             overflow_irq_out,
	output logic [15:0]      count_out
);
	import sbtc_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	logic [7:0]  timer_control_reg;
	logic [15:0] count_reg;
	logic [7:0]  high_buffer_reg;
	logic        overflow_flag_reg;
	logic        overflow_irq_enable_reg;
	logic        companion_osc_enable_reg;
	sbtc_bus_t   bus_state_reg;

	logic run_en;
	logic clk_sel;
	logic sync_dis;
	logic sixteen_bit_access_en;
	logic [1:0] presc_sel;
	assign run_en    = timer_control_reg[sbtc_bit_run_enable];
	assign clk_sel   = timer_control_reg[sbtc_bit_clock_source_sel];
	assign sync_dis  = timer_control_reg[sbtc_bit_sync_disable];
	assign sixteen_bit_access_en = timer_control_reg[sbtc_bit_sixteen_bit_access];
	assign presc_sel = {timer_control_reg[sbtc_bit_prescale_hi],
		timer_control_reg[sbtc_bit_prescale_lo]};

	// ****************************************
	// bus decode: every access answers one cycle after request
	// ****************************************
	logic acc;
	logic wr_low;
	logic wr_high;
	logic wr_ctrl;
	logic wr_irq;
	logic rd_low;
	assign acc     = (avs_read_in || avs_write_in) && bus_state_reg == sbtc_bus_idle;
	assign wr_low  = acc && avs_write_in && avs_byteenable_in[0]
		&& avs_address_in == sbtc_off_count_low_byte;
	assign wr_high = acc && avs_write_in && avs_byteenable_in[0]
		&& avs_address_in == sbtc_off_count_high_byte;
	assign wr_ctrl = acc && avs_write_in && avs_byteenable_in[0]
		&& avs_address_in == sbtc_off_timer_control;
	assign wr_irq  = acc && avs_write_in && avs_byteenable_in[0]
		&& avs_address_in == sbtc_off_irq_regs;
	assign rd_low  = acc && avs_read_in && avs_address_in == sbtc_off_count_low_byte;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bus_state_reg       <= sbtc_bus_idle;
			avs_waitrequest_out <= 1'b1;
		end else begin
			unique case (bus_state_reg)
				sbtc_bus_idle: begin
					bus_state_reg       <= acc ? sbtc_bus_ack : sbtc_bus_idle;
					avs_waitrequest_out <= ~acc;
				end
				sbtc_bus_ack: begin
					bus_state_reg       <= sbtc_bus_idle;
					avs_waitrequest_out <= 1'b1;
				end
				default: begin
					bus_state_reg       <= sbtc_bus_idle;
					avs_waitrequest_out <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (acc && avs_read_in) begin
			unique case (avs_address_in)
				sbtc_off_count_low_byte:  avs_readdata_out <= {24'h0, count_reg[7:0]};
				sbtc_off_count_high_byte: avs_readdata_out <=
					{24'h0, sixteen_bit_access_en ? high_buffer_reg : count_reg[15:8]};
				sbtc_off_timer_control:   avs_readdata_out <= {24'h0, timer_control_reg};
				sbtc_off_irq_regs:        avs_readdata_out <= {29'h0,
					companion_osc_enable_reg, overflow_irq_enable_reg, overflow_flag_reg};
				default:                  avs_readdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// control and irq configuration
	// ****************************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			timer_control_reg <= sbtc_rst_timer_control;
		end else if (wr_ctrl) begin
			timer_control_reg <= avs_writedata_in[7:0];
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			overflow_irq_enable_reg  <= 1'b0;
			companion_osc_enable_reg <= 1'b0;
		end else if (wr_irq) begin
			overflow_irq_enable_reg  <= avs_writedata_in[sbtc_bit_overflow_irq_enable];
			companion_osc_enable_reg <= avs_writedata_in[sbtc_bit_companion_osc_enable];
		end
	end

	// ****************************************
	// external clock path
	// ****************************************
	logic ext_src;
	logic ext_synced;
	logic ext_raw_q1;
	logic ext_raw_q2;
	logic ext_level;
	logic ext_prev_reg;
	logic seen_fall_reg;
	// source pick: companion oscillator when enabled
	assign ext_src = companion_osc_enable_reg ? companion_osc_clk_in : ext_count_clock_pin_in;

	sbtc_sync3 u_sync (
		.clk_in (ref_clk_in),
		.rst_in (rst_in),
		.d_in   (ext_src),
		.q_out  (ext_synced)
	);
	// the shared pins are outside this clock, so each passes the agreement filter
	logic [1:0] pins_synced;
	for (genvar g = 0; g < 2; g++) begin : g_pin_sync
		sbtc_sync3 u_pin_sync (
			.clk_in (ref_clk_in),
			.rst_in (rst_in),
			.d_in   (shared_pins_in[g]),
			.q_out  (pins_synced[g])
		);
	end

	// unsynchronised path still needs sampling to live in this clock; it skips the
	// agreement filter, so it reacts two cycles sooner but may glitch
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ext_raw_q1 <= 1'b0;
			ext_raw_q2 <= 1'b0;
		end else begin
			ext_raw_q1 <= ext_src;
			ext_raw_q2 <= ext_raw_q1;
		end
	end

	assign ext_level = sync_dis ? ext_raw_q2 : ext_synced;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ext_prev_reg  <= 1'b0;
			seen_fall_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_level;
			if (!clk_sel || !run_en) begin
				seen_fall_reg <= 1'b0;
			end else if (ext_prev_reg && !ext_level) begin
				seen_fall_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// count path
	// ****************************************
	logic raw_tick;
	logic pre_tick;
	logic async_mode;
	assign async_mode = clk_sel && sync_dis;
	assign raw_tick = run_en && (clk_sel ? (seen_fall_reg && !ext_prev_reg && ext_level)
		: 1'b1);

	sbtc_prescale #(.WIDTH(3)) u_presc (
		.clk_in   (ref_clk_in),
		.rst_in   (rst_in),
		.clear_in (wr_low),
		.sel_in   (presc_sel),
		.tick_in  (raw_tick),
		.tick_out (pre_tick)
	);

	logic u1_this;
	logic u2_this;
	assign u1_this = timer_control_reg[sbtc_bit_time_base_select_hi];
	assign u2_this = timer_control_reg[sbtc_bit_time_base_select_hi]
		|| timer_control_reg[sbtc_bit_time_base_select_lo];

	logic evt_one;
	logic evt_two;
	logic evt_reset;
	assign evt_one   = capcomp_unit_one_trig_in && u1_this
		&& capcomp_unit_one_mode_in == sbtc_mode_special_evt;
	assign evt_two   = capcomp_unit_two_trig_in && u2_this
		&& capcomp_unit_two_mode_in == sbtc_mode_special_evt;
	assign evt_reset = (evt_one || evt_two) && !async_mode;

	logic overflow;
	assign overflow = pre_tick && count_reg == 16'hffff;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_reg <= sbtc_rst_count;
		end else if (wr_low) begin
			count_reg <= {sixteen_bit_access_en ? high_buffer_reg : count_reg[15:8],
				avs_writedata_in[7:0]};
		end else if (wr_high && !sixteen_bit_access_en) begin
			count_reg <= {avs_writedata_in[7:0], count_reg[7:0]};
		end else if (evt_reset) begin
			count_reg <= sbtc_rst_count;
		end else if (pre_tick) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			high_buffer_reg <= 8'h00;
		end else if (wr_high && sixteen_bit_access_en) begin
			high_buffer_reg <= avs_writedata_in[7:0];
		end else if (rd_low && sixteen_bit_access_en) begin
			high_buffer_reg <= count_reg[15:8];
		end
	end

	// flag set from wrap or a bus write of 1, never from trigger
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			overflow_flag_reg <= 1'b0;
		end else if (overflow && !wr_low && !(wr_high && !sixteen_bit_access_en)
			&& !evt_reset) begin
			overflow_flag_reg <= 1'b1;
		end else if (wr_irq) begin
			overflow_flag_reg <= avs_writedata_in[sbtc_bit_overflow_flag];
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			overflow_irq_out       <= 1'b0;
			shared_pins_read_out   <= 2'b00;
			unit_one_uses_this_out <= 1'b0;
			unit_two_uses_this_out <= 1'b0;
			count_out              <= sbtc_rst_count;
		end else begin
			overflow_irq_out <= overflow_flag_reg && overflow_irq_enable_reg;
			// pins read zero with osc on
			shared_pins_read_out   <= companion_osc_enable_reg ? 2'b00 : pins_synced;
			unit_one_uses_this_out <= u1_this;
			unit_two_uses_this_out <= u2_this;
			count_out              <= count_reg;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	a_wrap_to_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(overflow && !wr_low && !wr_high && !evt_reset) |=> count_reg == 16'h0000)
		else $error("count did not wrap to zero");
	a_flag_on_wrap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(overflow && !wr_low && !wr_high && !evt_reset) |=> overflow_flag_reg)
		else $error("overflow flag not set");
	a_halt_holds: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(!run_en && !wr_low && !wr_high && !evt_reset) |=> $stable(count_reg))
		else $error("count moved while halted");
	a_evt_clears: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(evt_reset && !wr_low && !wr_high) |=> count_reg == 16'h0000)
		else $error("special event did not reset");
	a_write_wins: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(wr_low && evt_reset) |=> count_reg[7:0] == $past(avs_writedata_in[7:0]))
		else $error("write lost to special event");
	a_buf_latch: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(rd_low && sixteen_bit_access_en && !wr_high)
		|=> high_buffer_reg == $past(count_reg[15:8]))
		else $error("high buffer not latched");
	a_hi_hidden: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(wr_high && sixteen_bit_access_en && !pre_tick && !evt_reset)
		|=> $stable(count_reg[15:8]))
		else $error("live high byte written directly");
	a_timer_tick: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(run_en && !clk_sel && presc_sel == 2'b00 && !wr_low && !wr_high && !evt_reset)
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("timer mode missed a cycle");
	a_osc_pins: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		companion_osc_enable_reg |=> shared_pins_read_out == 2'b00)
		else $error("shared pins not read as zero");
	a_ack_one: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		acc |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
		else $error("bus answer not one cycle");
	c_overflow: cover property (@(posedge ref_clk_in) disable iff (rst_in) overflow);
	c_evt:      cover property (@(posedge ref_clk_in) disable iff (rst_in) evt_reset);
	c_ext:      cover property (@(posedge ref_clk_in) disable iff (rst_in) clk_sel && pre_tick);
	c_buf_read: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		rd_low && sixteen_bit_access_en);
endmodule
`default_nettype wire

// ### shared/sbtc_pkg.sv
// sbtc_pkg: register map, field positions and reset values of the 16-bit timer/counter
// assumes a 32-bit avalon-mm slave with word-aligned registers
package sbtc_pkg;
	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [3:0] sbtc_off_count_low_byte  = 4'h0;
	localparam logic [3:0] sbtc_off_count_high_byte = 4'h4;
	localparam logic [3:0] sbtc_off_timer_control   = 4'h8;
	localparam logic [3:0] sbtc_off_irq_regs        = 4'hc;
	// ****************************************
	// timer_control fields
	// ****************************************
	localparam int sbtc_bit_run_enable           = 0;
	localparam int sbtc_bit_clock_source_sel     = 1;
	localparam int sbtc_bit_sync_disable         = 2;
	localparam int sbtc_bit_time_base_select_lo  = 3;
	localparam int sbtc_bit_prescale_lo          = 4;
	localparam int sbtc_bit_prescale_hi          = 5;
	localparam int sbtc_bit_time_base_select_hi  = 6;
	localparam int sbtc_bit_sixteen_bit_access   = 7;
	// ****************************************
	// irq register fields (flag, enable, companion osc enable)
	// ****************************************
	localparam int sbtc_bit_overflow_flag        = 0;
	localparam int sbtc_bit_overflow_irq_enable  = 1;
	localparam int sbtc_bit_companion_osc_enable = 2;
	// ****************************************
	// reset values and constants
	// ****************************************
	localparam logic [7:0]  sbtc_rst_timer_control = 8'h00;
	localparam logic [15:0] sbtc_rst_count         = 16'h0000;
	localparam logic [3:0]  sbtc_mode_special_evt  = 4'hb;
	typedef enum logic [1:0] {
		sbtc_bus_idle = 2'b00,
		sbtc_bus_ack  = 2'b01
	} sbtc_bus_t;
endpackage

// ### sim/sbtc_ext_src.sv
// sbtc_ext_src: far-side model, external count pin and companion oscillator
// assumes the bench calls burst while the timer runs; clocks idle low otherwise
`timescale 1ns/1ns
`default_nettype none
module sbtc_ext_src (
	input  wire logic ref_clk_in,
	output var  logic pin_clk_out,
	output var  logic osc_clk_out
);
	// ********
	// pulse bursts
	// ********
	initial begin
		pin_clk_out = 1'b0;
		osc_clk_out = 1'b0;
	end
	// source is a count input only
	// the odd offset keeps edges unrelated in phase to the instruction clock
	task automatic burst(input logic use_osc, input int n, input int half);
		for (int i = 0; i < n; i++) begin
			repeat (half) @(posedge ref_clk_in);
			#37;
			if (use_osc) begin
				osc_clk_out = 1'b1;
			end else begin
				pin_clk_out = 1'b1;
			end
			repeat (half) @(posedge ref_clk_in);
			#37;
			osc_clk_out = 1'b0;
			pin_clk_out = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ### sim/sbtc_timer_tb_top.sv
// sbtc_timer_tb_top: self-checking bench for the 16-bit timer/counter
// assumes sbtc_pkg offsets; bus answers are awaited, never counted
`timescale 1ns/1ns
`default_nettype none
module sbtc_timer_tb_top;
	import sbtc_pkg::*;
	typedef struct {logic [7:0] ctrl; int exp;} sbtc_row_t;
	logic        ref_clk_in;
	logic        rst_in;
	logic [3:0]  avs_address_in;
	logic        avs_read_in;
	logic        avs_write_in;
	logic [31:0] avs_writedata_in;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        ext_pin;
	logic        osc_clk;
	logic        trig_one;
	logic        trig_two;
	logic        arm_trig;
	logic [3:0]  cc_mode;
	logic [1:0]  pins_read;
	logic        uses_one;
	logic        uses_two;
	logic        irq;
	logic [15:0] count_out;
	logic [7:0]  rd;
	int          err_count;
	int          check_count;
	sbtc_row_t   rows[5] = '{'{8'h01, 80}, '{8'h11, 40}, '{8'h21, 20}, '{8'h31, 10}, '{8'h30, 0}};
	logic [7:0]  tb_ctrl[3] = '{8'h00, 8'h08, 8'h40};
	logic [1:0]  tb_exp[3] = '{2'b00, 2'b01, 2'b11};

	sbtc_timer u_sbtc_timer (
		.ref_clk_in               (ref_clk_in),
		.rst_in                   (rst_in),
		.avs_address_in           (avs_address_in),
		.avs_read_in              (avs_read_in),
		.avs_write_in             (avs_write_in),
		.avs_writedata_in         (avs_writedata_in),
		.avs_byteenable_in        (4'hf),
		.avs_readdata_out         (avs_readdata_out),
		.avs_waitrequest_out      (avs_waitrequest_out),
		.ext_count_clock_pin_in   (ext_pin),
		.companion_osc_clk_in     (osc_clk),
		.shared_pins_in           (2'h3),
		.capcomp_unit_one_trig_in (trig_one),
		.capcomp_unit_two_trig_in (trig_two),
		.capcomp_unit_one_mode_in (cc_mode),
		.capcomp_unit_two_mode_in (cc_mode),
		.shared_pins_read_out     (pins_read),
		.unit_one_uses_this_out   (uses_one),
		.unit_two_uses_this_out   (uses_two),
		.overflow_irq_out         (irq),
		.count_out                (count_out)
	);
	sbtc_ext_src u_sbtc_ext_src (
		.ref_clk_in  (ref_clk_in),
		.pin_clk_out (ext_pin),
		.osc_clk_out (osc_clk)
	);

	// ********
	// helpers
	// ********
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// counts through a free-running clock may land one either side
	task automatic near(input string name, input int exp, input logic [7:0] got);
		check_count++;
		if ($isunknown(got) || int'(got) < exp - 1 || int'(got) > exp + 1) begin
			err_count++;
			$display("wrong value %s expected %0d seen %h", name, exp, got);
		end
	endtask
	// one request held until waitrequest is seen low, then a gap edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		avs_address_in   <= a;
		avs_writedata_in <= {24'h000000, d};
		avs_write_in     <= wr;
		avs_read_in      <= !wr;
		trig_one         <= arm_trig;
		do begin
			@(posedge ref_clk_in);
			trig_one <= 1'b0;
		end while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out[7:0];
		avs_write_in <= 1'b0;
		avs_read_in  <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task automatic clear_count();
		bus(1'b1, sbtc_off_timer_control, 8'h00);
		bus(1'b1, sbtc_off_count_high_byte, 8'h00);
		bus(1'b1, sbtc_off_count_low_byte, 8'h00);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ********
	// clock, watchdog and tests
	// ********
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		#(100 * 20000);
		err_count++;
		end_sim();
	end
	initial begin
		rst_in = 1'b1;
		avs_address_in = 4'h0;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = 32'h00000000;
		trig_one = 1'b0;
		trig_two = 1'b0;
		cc_mode = 4'hb;
		arm_trig = 1'b0;
		err_count = 0;
		check_count = 0;
		repeat (10) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		bus(1'b0, sbtc_off_timer_control, 8'h00);
		chk("control", 16'h0000, {8'h00, rd});
		bus(1'b0, sbtc_off_irq_regs, 8'h00);
		chk("irq regs", 16'h0000, {8'h00, rd});
		// prescale rows, 80 instruction cycles each
		foreach (rows[i]) begin
			clear_count();
			bus(1'b1, sbtc_off_timer_control, rows[i].ctrl);
			repeat (77) @(posedge ref_clk_in);
			bus(1'b1, sbtc_off_timer_control, 8'h00);
			bus(1'b0, sbtc_off_count_low_byte, 8'h00);
			near("prescaled count", rows[i].exp, rd);
		end
		foreach (tb_ctrl[i]) begin
			bus(1'b1, sbtc_off_timer_control, tb_ctrl[i]);
			chk("time base", {14'h0000, tb_exp[i]}, {14'h0000, uses_one, uses_two});
		end
		bus(1'b1, sbtc_off_timer_control, 8'h80);
		bus(1'b1, sbtc_off_count_low_byte, 8'h00);
		bus(1'b1, sbtc_off_count_high_byte, 8'h12);
		chk("count after high write", 16'h0000, count_out);
		bus(1'b1, sbtc_off_count_low_byte, 8'h34);
		chk("count after low write", 16'h1234, count_out);
		bus(1'b1, sbtc_off_count_high_byte, 8'h77);
		bus(1'b0, sbtc_off_count_high_byte, 8'h00);
		chk("high buffer", 16'h0077, {8'h00, rd});
		chk("live count", 16'h1234, count_out);
		bus(1'b0, sbtc_off_count_low_byte, 8'h00);
		bus(1'b0, sbtc_off_count_high_byte, 8'h00);
		chk("latched high", 16'h0012, {8'h00, rd});
		bus(1'b1, sbtc_off_timer_control, 8'h00);
		bus(1'b1, sbtc_off_count_high_byte, 8'h56);
		chk("byte mode high", 16'h5634, count_out);
		bus(1'b1, sbtc_off_count_high_byte, 8'hff);
		bus(1'b1, sbtc_off_count_low_byte, 8'hfd);
		bus(1'b1, sbtc_off_irq_regs, 8'h02);
		bus(1'b1, sbtc_off_timer_control, 8'h01);
		repeat (10) @(posedge ref_clk_in);
		bus(1'b1, sbtc_off_timer_control, 8'h00);
		chk("wrapped high", 16'h0000, {8'h00, count_out[15:8]});
		chk("irq line", 16'h0001, {15'h0000, irq});
		bus(1'b0, sbtc_off_irq_regs, 8'h00);
		chk("flag", 16'h0003, {8'h00, rd});
		bus(1'b1, sbtc_off_irq_regs, 8'h02);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		bus(1'b1, sbtc_off_irq_regs, 8'h01);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		bus(1'b1, sbtc_off_irq_regs, 8'h00);
		bus(1'b1, sbtc_off_timer_control, 8'h40);
		bus(1'b1, sbtc_off_count_high_byte, 8'hff);
		bus(1'b1, sbtc_off_count_low_byte, 8'hff);
		trig_two <= 1'b1;
		@(posedge ref_clk_in);
		trig_two <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		chk("unit two reset", 16'h0000, count_out);
		bus(1'b0, sbtc_off_irq_regs, 8'h00);
		chk("no flag from unit two", 16'h0000, {8'h00, rd});
		arm_trig = 1'b1;
		bus(1'b1, sbtc_off_count_low_byte, 8'h55);
		arm_trig = 1'b0;
		chk("write beats reset", 16'h0055, count_out);
		bus(1'b1, sbtc_off_count_high_byte, 8'h00);
		arm_trig = 1'b1;
		bus(1'b0, sbtc_off_timer_control, 8'h00);
		arm_trig = 1'b0;
		repeat (2) @(posedge ref_clk_in);
		chk("unit one reset", 16'h0000, count_out);
		// other compare modes and async mode leave the count alone
		bus(1'b1, sbtc_off_count_low_byte, 8'h66);
		cc_mode <= 4'ha;
		trig_two <= 1'b1;
		@(posedge ref_clk_in);
		trig_two <= 1'b0;
		cc_mode <= 4'hb;
		repeat (2) @(posedge ref_clk_in);
		chk("other mode kept", 16'h0066, count_out);
		bus(1'b1, sbtc_off_timer_control, 8'h46);
		trig_two <= 1'b1;
		@(posedge ref_clk_in);
		trig_two <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		chk("async mode kept", 16'h0066, count_out);
		for (int s = 0; s < 3; s++) begin
			clear_count();
			bus(1'b1, sbtc_off_irq_regs, (s == 2) ? 8'h04 : 8'h00);
			bus(1'b1, sbtc_off_timer_control, (s == 1) ? 8'h07 : 8'h03);
			u_sbtc_ext_src.burst(s == 2, 5, 4);
			repeat (8) @(posedge ref_clk_in);
			if (s == 2) begin
				chk("pins read", 16'h0000, {14'h0000, pins_read});
			end
			bus(1'b1, sbtc_off_timer_control, 8'h00);
			bus(1'b0, sbtc_off_count_low_byte, 8'h00);
			chk("external count", 16'h0004, {8'h00, rd});
		end
		bus(1'b1, sbtc_off_irq_regs, 8'h00);
		chk("pins read", 16'h0003, {14'h0000, pins_read});
		bus(1'b1, sbtc_off_timer_control, 8'h81);
		repeat (5) @(posedge ref_clk_in);
		rst_in <= 1'b1;
		repeat (10) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		chk("count after reset", 16'h0000, count_out);
		bus(1'b0, sbtc_off_timer_control, 8'h00);
		chk("control after reset", 16'h0000, {8'h00, rd});
		end_sim();
	end
endmodule
`default_nettype wire
